// >>> verilog/txpt_pkg.sv
/*
  constants for the transmit pulse template and dac trim register bank.
  assumes an 8-bit register space behind a 32-bit avalon-mm slave.
*/
package txpt_pkg;
  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 32;
  // printed offsets are not word multiples: they are indices, byte = 4*idx
  localparam logic [7:0]  IDX_TMPL_ADDR = 8'hf2;
  localparam logic [7:0]  IDX_TMPL_DATA = 8'hf3;
  localparam logic [7:0]  IDX_NEG_TRIM  = 8'hf4;
  localparam logic [7:0]  IDX_POS_TRIM  = 8'hf5;
  localparam logic [7:0]  IDX_TRIM_SRC  = 8'hf6;
  localparam logic [7:0]  IDX_TMPL_RDBK = 8'hf7;
  localparam int          UI_COUNT      = 5;
  localparam int          SAMPLE_COUNT  = 24;
  localparam int          ENTRIES       = UI_COUNT * SAMPLE_COUNT;
  localparam logic [2:0]  UI_MAX        = 3'h4;
  localparam logic [4:0]  SAMPLE_MAX    = 5'h17;
  localparam int          ADDR_UI_LSB   = 0;
  localparam int          ADDR_SMP_LSB  = 3;
  localparam int          VAL_W         = 7;
  localparam int          TRIM_W        = 7;
  localparam int          TRIM_EN_N_BIT = 0;
  localparam int          TRIM_DIR_BIT  = 6;
  localparam logic [7:0]  TMPL_ADDR_RST = 8'h00;
  localparam logic [6:0]  TRIM_RST      = 7'h00;
  localparam logic        SRC_RST       = 1'b0;
  localparam logic [31:0] UNMAPPED_RD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    TXPT_IDLE = 2'b00,
    TXPT_ACK  = 2'b01
  } txpt_bus_t;
endpackage

// >>> verilog/txpt_regs.sv
/*
  register bank of the transmit pulse shaper: indirect template store,
  negative and positive dac trim control, and trim source selection.
  assumes avalon-mm master in the core clock domain, synchronous pins,
  and the analog fuse array and line driver outside this module.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module txpt_regs #(
  parameter int ENTRY_N = txpt_pkg::ENTRIES
) (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        CLK_EN_I,
  input  wire logic [txpt_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                        AVS_READ_I,
  input  wire logic                        AVS_WRITE_I,
  input  wire logic [txpt_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]                  AVS_BYTEENABLE_I,
  output logic      [txpt_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic                             AVS_WAITREQUEST_O,
  input  wire logic                        TX_LINE_UNIT_HOLD_I,
  input  wire logic                        FUSE_BLOW_PIN_I,
  input  wire logic                        ANALOG_TEST_MODE_I,
  input  wire logic [6:0]                  NEG_FUSE_VALUE_I,
  input  wire logic [6:0]                  POS_FUSE_VALUE_I,
  input  wire logic [6:0]                  RD_TMPL_INDEX_I,
  output logic      [6:0]                  RD_TMPL_VALUE_O,
  output logic      [6:0]                  NEGATIVE_CURRENT_DAC_O,
  output logic      [6:0]                  POSITIVE_CURRENT_DAC_O,
  output logic                             NEG_FUSE_OVERRIDE_O,
  output logic                             POS_FUSE_OVERRIDE_O,
  output logic                             NEG_FUSE_BLOW_O,
  output logic                             POS_FUSE_BLOW_O,
  output logic                             NEG_FUSE_READ_EN_O,
  output logic                             POS_FUSE_READ_EN_O
);
  import txpt_pkg::*;

  // channel 0 trims the negative current dac, channel 1 the positive one
  localparam int CH_N   = 2;
  localparam int CH_NEG = 0;
  localparam int CH_POS = 1;

  typedef struct packed {
    txpt_bus_t                   bus;
    logic [DATA_W-1:0]           rdata;
    logic [7:0]                  tmpl_addr;
    logic [CH_N-1:0][TRIM_W-1:0] trim;
    logic                        trim_src;
    logic [CH_N-1:0]             armed;
    logic [VAL_W-1:0]            rd_val;
    logic [ENTRY_N*VAL_W-1:0]    tmpl;
  } txpt_state_t;

  txpt_state_t state_ff;
  txpt_state_t nxt_state;

  // flat entry index, or ENTRY_N when either field is out of range
  function automatic logic [7:0] entry_of(input logic [7:0] a);
    logic [2:0] ui;
    logic [4:0] smp;
    ui  = a[ADDR_UI_LSB +: 3];
    smp = a[ADDR_SMP_LSB +: 5];
    if (ui > UI_MAX || smp > SAMPLE_MAX) begin
      entry_of = 8'(ENTRY_N);
    end else begin
      entry_of = 8'(ui * SAMPLE_COUNT + smp);
    end
  endfunction

  // trim write: bus data or fuse data, fuse data only once outputs armed
  function automatic logic [6:0] trim_next(input logic [6:0] cur,
                                           input logic [6:0] wr,
                                           input logic [6:0] fuse,
                                           input logic src,
                                           input logic armed);
    trim_next = cur;
    if (src) begin
      trim_next = wr;
    end else if (armed) begin
      trim_next = {fuse[6:1], cur[TRIM_EN_N_BIT]};
    end
  endfunction

  // fuse-mode write with the enable bit high arms; the next one disarms
  function automatic logic arm_next(input logic src,
                                    input logic armed,
                                    input logic en_bit);
    arm_next = 1'b0;
    if (!src && !armed) begin
      arm_next = en_bit;
    end
  endfunction

  // stored entry for the shaper readout, zero past the last entry
  function automatic logic [VAL_W-1:0] tmpl_read(
    input logic [ENTRY_N*VAL_W-1:0] store,
    input logic [6:0]               index
  );
    tmpl_read = '0;
    if (index < 7'(ENTRY_N)) begin
      tmpl_read = store[index*VAL_W +: VAL_W];
    end
  endfunction

  logic [7:0]        idx;
  logic [7:0]        wbyte;
  logic [7:0]        ent;
  logic              req;
  logic              ack;
  logic              wr_acc;
  logic              wr_addr;
  logic              wr_data;
  logic              wr_src;
  logic [CH_N-1:0]   wr_trim;
  logic [6:0]        fuse_in [CH_N];
  logic [CH_N-1:0]   ovr;
  logic [CH_N-1:0]   blow;
  logic [DATA_W-1:0] rd_mux;

  assign idx    = AVS_ADDRESS_I[ADDR_W-1:2];
  assign wbyte  = AVS_WRITEDATA_I[7:0];
  assign ent    = entry_of(state_ff.tmpl_addr);
  assign req    = AVS_READ_I || AVS_WRITE_I;
  // the answer edge is the single cycle spent in the ack state
  assign ack    = req && state_ff.bus == TXPT_ACK;
  // writes land on the answer edge only, and only with the low lane on
  assign wr_acc = AVS_WRITE_I && AVS_BYTEENABLE_I[0] && ack;

  assign fuse_in[CH_NEG] = NEG_FUSE_VALUE_I;
  assign fuse_in[CH_POS] = POS_FUSE_VALUE_I;

  // one strobe per register, so the next-state logic stays flat
  always_comb begin
    wr_addr = 1'b0;
    wr_data = 1'b0;
    wr_src  = 1'b0;
    wr_trim = '0;
    if (wr_acc) begin
      case (idx)
        IDX_TMPL_ADDR: begin
          wr_addr = 1'b1;
        end
        IDX_TMPL_DATA: begin
          wr_data = 1'b1;
        end
        IDX_NEG_TRIM: begin
          wr_trim[CH_NEG] = 1'b1;
        end
        IDX_POS_TRIM: begin
          wr_trim[CH_POS] = 1'b1;
        end
        IDX_TRIM_SRC: begin
          wr_src = 1'b1;
        end
        default: begin
          wr_trim = '0;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = UNMAPPED_RD;
    case (idx)
      IDX_TMPL_ADDR: begin
        rd_mux = {24'h0, state_ff.tmpl_addr};
      end
      IDX_TMPL_DATA: begin
        // write-only: reads return zero and leave the store alone
        rd_mux = UNMAPPED_RD;
      end
      IDX_NEG_TRIM: begin
        rd_mux = {25'h0, state_ff.trim[CH_NEG]};
      end
      IDX_POS_TRIM: begin
        rd_mux = {25'h0, state_ff.trim[CH_POS]};
      end
      IDX_TRIM_SRC: begin
        rd_mux = {31'h0, state_ff.trim_src};
      end
      IDX_TMPL_RDBK: begin
        rd_mux = {24'h0, 1'b0, state_ff.armed[CH_NEG],
                  state_ff.armed[CH_POS], ent[4:0]};
      end
      default: begin
        rd_mux = UNMAPPED_RD;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;

    case (state_ff.bus)
      TXPT_IDLE: begin
        if (req) begin
          nxt_state.bus   = TXPT_ACK;
          // read data are caught here and stand through the answer edge
          nxt_state.rdata = AVS_READ_I ? rd_mux : UNMAPPED_RD;
        end
      end
      TXPT_ACK: begin
        nxt_state.bus = TXPT_IDLE;
      end
      default: begin
        nxt_state.bus = TXPT_IDLE;
      end
    endcase

    if (wr_addr) begin
      nxt_state.tmpl_addr = wbyte;
    end

    // an undefined address decodes past the last entry and stores nothing
    if (wr_data && ent < 8'(ENTRY_N)) begin
      nxt_state.tmpl[ent*VAL_W +: VAL_W] = wbyte[VAL_W-1:0];
    end

    for (int c = 0; c < CH_N; c++) begin
      if (wr_trim[c]) begin
        nxt_state.trim[c]  = trim_next(state_ff.trim[c],
                                       wbyte[TRIM_W-1:0],
                                       fuse_in[c],
                                       state_ff.trim_src,
                                       state_ff.armed[c]);
        nxt_state.armed[c] = arm_next(state_ff.trim_src,
                                      state_ff.armed[c],
                                      wbyte[TRIM_EN_N_BIT]);
      end
    end

    if (wr_src) begin
      nxt_state.trim_src = wbyte[0];
    end

    nxt_state.rd_val = tmpl_read(state_ff.tmpl, RD_TMPL_INDEX_I);

    // hold wins over any write landing on the same edge
    if (TX_LINE_UNIT_HOLD_I) begin
      nxt_state.tmpl_addr = TMPL_ADDR_RST;
      nxt_state.trim      = {CH_N{TRIM_RST}};
      nxt_state.trim_src  = SRC_RST;
      nxt_state.armed     = '0;
      nxt_state.tmpl      = '0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= '0;
    end else if (CLK_EN_I) begin
      state_ff <= nxt_state;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      logic en_n;
      assign en_n = state_ff.trim[g][TRIM_EN_N_BIT];
      // override does not depend on analog test mode
      assign ovr[g]  = !en_n && !FUSE_BLOW_PIN_I;
      // blowing needs analog test mode on top of the pin
      assign blow[g] = !en_n && FUSE_BLOW_PIN_I
                       && ANALOG_TEST_MODE_I;
    end
  endgenerate

  // request waits one cycle, then the registered answer is released
  assign AVS_WAITREQUEST_O      = req && state_ff.bus != TXPT_ACK;
  assign AVS_READDATA_O         = state_ff.rdata;
  assign RD_TMPL_VALUE_O        = state_ff.rd_val;
  assign NEGATIVE_CURRENT_DAC_O = state_ff.trim[CH_NEG];
  assign POSITIVE_CURRENT_DAC_O = state_ff.trim[CH_POS];
  assign NEG_FUSE_OVERRIDE_O    = ovr[CH_NEG];
  assign POS_FUSE_OVERRIDE_O    = ovr[CH_POS];
  assign NEG_FUSE_BLOW_O        = blow[CH_NEG];
  assign POS_FUSE_BLOW_O        = blow[CH_POS];
  assign NEG_FUSE_READ_EN_O     = state_ff.armed[CH_NEG];
  assign POS_FUSE_READ_EN_O     = state_ff.armed[CH_POS];
endmodule

// >>> verif/txpt_regs_monitor.sv
/* port checker of txpt_regs: handshake, hold, trims, fuse outputs.
   assumes a bind onto txpt_regs and one clock domain. */
`timescale 1ns/1ns
module txpt_regs_monitor (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic [9:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        TX_LINE_UNIT_HOLD_I,
  input wire logic        FUSE_BLOW_PIN_I,
  input wire logic        ANALOG_TEST_MODE_I,
  input wire logic [6:0]  NEGATIVE_CURRENT_DAC_O,
  input wire logic [6:0]  POSITIVE_CURRENT_DAC_O,
  input wire logic        NEG_FUSE_OVERRIDE_O,
  input wire logic        POS_FUSE_OVERRIDE_O,
  input wire logic        NEG_FUSE_BLOW_O,
  input wire logic        POS_FUSE_BLOW_O
);
  import txpt_pkg::*;
  logic [6:0] n, p;
  logic       req, ack;
  assign n = NEGATIVE_CURRENT_DAC_O;
  assign p = POSITIVE_CURRENT_DAC_O;
  assign req = AVS_READ_I || AVS_WRITE_I;
  assign ack = req && !AVS_WAITREQUEST_O;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_req; $rose(req); endsequence
  sequence s_ans; AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O; endsequence
  property p_hs; s_req |-> s_ans; endproperty
  a_hs: assert property (p_hs) else $error("wait state wrong");
  property p_idle; !req |-> !AVS_WAITREQUEST_O; endproperty
  a_idle: assert property (p_idle) else $error("idle wait");
  property p_hold; TX_LINE_UNIT_HOLD_I |=> n == 7'h00 && p == 7'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("hold no reset");
  property p_keep; !AVS_WRITE_I && !TX_LINE_UNIT_HOLD_I |=> $stable(n)
    && $stable(p); endproperty
  a_keep: assert property (p_keep) else $error("trim moved");
  property p_ovr; NEG_FUSE_OVERRIDE_O == (!n[0] && !FUSE_BLOW_PIN_I) &&
    POS_FUSE_OVERRIDE_O == (!p[0] && !FUSE_BLOW_PIN_I); endproperty
  a_ovr: assert property (p_ovr) else $error("override wrong");
  property p_blow; NEG_FUSE_BLOW_O == (!n[0] && FUSE_BLOW_PIN_I &&
    ANALOG_TEST_MODE_I) && POS_FUSE_BLOW_O == (!p[0] &&
    FUSE_BLOW_PIN_I && ANALOG_TEST_MODE_I); endproperty
  a_blow: assert property (p_blow) else $error("blow wrong");
  property p_rdwo; AVS_READ_I && ack && AVS_ADDRESS_I[9:2] ==
    IDX_TMPL_DATA |-> AVS_READDATA_O == 32'h0000_0000; endproperty
  a_rdwo: assert property (p_rdwo) else $error("data reg read");
  property p_lane; AVS_READ_I && ack |-> AVS_READDATA_O[31:8] == 24'h0;
  endproperty
  a_lane: assert property (p_lane) else $error("upper lane set");
endmodule

// >>> verif/txpt_regs_tb_top.sv
/* self-checking bench of txpt_regs: template, trims, fuse load, hold.
   assumes package, design and monitor are compiled first. */
`timescale 1ns/1ns
module txpt_regs_tb_top;
  import txpt_pkg::*;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, hold = 0, pin = 0;
  logic        atm = 0, nre, pre, wq;
  logic [9:0]  addr = 0;
  logic [31:0] wdata = 0, rdata, q;
  logic [6:0]  nf = 0, pf = 0, ridx = 0, rval, nd, pd, v;
  logic [2:0]  ui;
  logic [4:0]  smp;
  logic [7:0]  ix;
  logic [7:0]  rl[6] = '{IDX_TMPL_ADDR, IDX_TMPL_DATA, IDX_NEG_TRIM,
                         IDX_POS_TRIM, IDX_TRIM_SRC, 8'h10};
  logic [7:0]  bad[8] = '{8'h08, 8'h15, 8'h01, 8'h2a, 8'h05, 8'h3f,
                          8'hc0, 8'h3f};
  integer      fail_count = 0, compares = 0, cyc = 0, seed = 89427, i;
  txpt_regs txpt_regs_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq),
    .TX_LINE_UNIT_HOLD_I(hold), .FUSE_BLOW_PIN_I(pin),
    .ANALOG_TEST_MODE_I(atm), .NEG_FUSE_VALUE_I(nf), .POS_FUSE_VALUE_I(pf),
    .RD_TMPL_INDEX_I(ridx), .RD_TMPL_VALUE_O(rval),
    .NEGATIVE_CURRENT_DAC_O(nd), .POSITIVE_CURRENT_DAC_O(pd),
    .NEG_FUSE_OVERRIDE_O(), .POS_FUSE_OVERRIDE_O(), .NEG_FUSE_BLOW_O(),
    .POS_FUSE_BLOW_O(), .NEG_FUSE_READ_EN_O(nre), .POS_FUSE_READ_EN_O(pre));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [6:0] tidx(logic [2:0] u, logic [4:0] s);
    return 7'(u * 24 + s);
  endfunction
  task automatic chk(string nm, logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] x, d);
    addr <= {x, 2'b00};
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tmpl(logic [6:0] k, e);
    ridx <= k;
    repeat (2) @(posedge clk);
    chk("tmpl_value", rval, e);
  endtask
  task automatic regs_zero;
    foreach (rl[j]) begin
      bus(0, rl[j], 8'h00);
      chk("reg_zero", q, 0);
    end
  endtask
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    pin <= 1'($random(seed));
    atm <= 1'($random(seed));
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    nf <= 7'($random(seed));
    pf <= 7'($random(seed));
    @(posedge clk);
    regs_zero;
    for (i = 0; i < 24; i++) begin
      ui = (i == 0) ? 3'h4 : 3'($unsigned($random(seed)) % 5);
      smp = (i == 0) ? 5'h17 : 5'($unsigned($random(seed)) % 24);
      v = 7'($random(seed));
      if (v == 7'h7f) v = 7'h7e;
      bus(1, IDX_TMPL_ADDR, {smp, ui});
      bus(0, IDX_TMPL_ADDR, 8'h00);
      chk("tmpl_addr", q, {smp, ui});
      bus(1, IDX_TMPL_DATA, {1'b0, v});
      tmpl(tidx(ui, smp), v);
    end
    for (i = 0; i < 8; i += 2) begin
      bus(1, IDX_TMPL_ADDR, bad[i]);
      bus(1, IDX_TMPL_DATA, bad[i+1]);
    end
    bus(0, IDX_TMPL_DATA, 8'h00);
    chk("tmpl_data_rd", q, 0);
    tmpl(7'd1, 7'h15);
    tmpl(7'd24, 7'h2a);
    for (i = 0; i < 2; i++) begin
      ix = IDX_NEG_TRIM + 8'(i);
      v = 7'($random(seed));
      bus(1, IDX_TRIM_SRC, 8'h01);
      bus(1, ix, {1'b0, v});
      bus(0, ix, 8'h00);
      chk("trim_rd", q, v);
      chk("trim_dac", i ? pd : nd, v);
      bus(1, IDX_TRIM_SRC, 8'h00);
      bus(1, ix, 8'h01);
      chk("armed", i ? pre : nre, 1'b1);
      chk("arm_keep", i ? pd : nd, v);
      bus(1, ix, 8'h01);
      chk("fuse_load", i ? pd : nd, {(i ? pf[6:1] : nf[6:1]), v[0]});
      chk("disarmed", i ? pre : nre, 1'b0);
      bus(1, IDX_TRIM_SRC, 8'h01);
      bus(1, ix, 8'h00);
    end
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    hold <= 1'b0;
    @(posedge clk);
    regs_zero;
    tmpl(tidx(3'h4, 5'h17), 7'h00);
    test_done;
  end
endmodule
bind txpt_regs txpt_regs_monitor txpt_regs_monitor_i (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .TX_LINE_UNIT_HOLD_I(TX_LINE_UNIT_HOLD_I),
  .FUSE_BLOW_PIN_I(FUSE_BLOW_PIN_I), .ANALOG_TEST_MODE_I(ANALOG_TEST_MODE_I),
  .NEGATIVE_CURRENT_DAC_O(NEGATIVE_CURRENT_DAC_O),
  .POSITIVE_CURRENT_DAC_O(POSITIVE_CURRENT_DAC_O),
  .NEG_FUSE_OVERRIDE_O(NEG_FUSE_OVERRIDE_O), .NEG_FUSE_BLOW_O(NEG_FUSE_BLOW_O),
  .POS_FUSE_OVERRIDE_O(POS_FUSE_OVERRIDE_O), .POS_FUSE_BLOW_O(POS_FUSE_BLOW_O));
